// ### sas_top.sv
// sas_top.sv: successive-approximation sequencer with result registers and result stream
// assumes: register values and write strobes come from the cpu side, synchronous to ref_clk;
// the comparator output is a settled digital level when each trial bit is taken
//
// Contract
// R1 - peripheral enable bit 5 turns on converter clock; set before other configuration
// R2 - conversion time in mode bits 5..1, select/scan mode in bit 6
// R3 - writing one to mode bit 7 starts conversion
// R4 - in timer trigger mode, start bit only arms a wait for a trigger
// R5 - sample the channel for a fixed time, then hold until conversion ends
// R6 - each conversion sets approximation bit 9 first, tap at half reference
// R7 - keep the top bit if input exceeds half reference, else clear it
// R8 - then set next lower bit, tap three or one quarter reference
// R9 - keep each trial bit when input reaches the tap, continue down to bit 0
// R10 - after ten decisions copy the approximation into the result registers
// R11 - raise conversion end interrupt in the same step as the result transfer
// R12 - repeat conversions while start bit is one; clearing it stops
// R13 - software waits one microsecond after enabling comparator before starting
// R14 - 16-bit result word and 8-bit result holding the upper eight bits
// R15 - result word equals approximation times 64, low six bits zero
// R16 - channel select write during conversion reinitialises it and restarts
// R17 - system reset clears result word and result byte to zero
// R18 - software and timer trigger modes chosen by the trigger mode register
// R19 - timer mode starts only with start bit one and either timer trigger
// R20 - timer trigger mid-conversion aborts; restart, or from scan slot 0
// R21 - select mode converts the one selected channel, stores, interrupts
// R22 - any mode, trigger mode or channel write mid-conversion aborts and restarts
// R23 - scan mode converts four channels from slot 0, interrupt after each
// R24 - sample and per-bit times are fixed clock counts from the time field
// R25 - comparator decision is a stable digital input when latched
`include "sas_map.svh"

module sas_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // filling side
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    // draining side
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic push;
    logic load;

    assign inReady = (count != (AW + 1)'(DEPTH));
    assign push = inValid && inReady;
    // output stage refills whenever it is empty or being taken
    assign load = (count != '0) && (!outValid || outReady);

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr <= '0;
        end else if (push) begin
            wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdPtr <= '0;
        end else if (load) begin
            rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
        end else if (push && !load) begin
            count <= count + 1'b1;
        end else if (load && !push) begin
            count <= count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            outValid <= 1'b0;
            outData <= '0;
        end else if (load) begin
            outValid <= 1'b1;
            outData <= mem[rdPtr];
        end else if (outReady) begin
            outValid <= 1'b0;
        end
    end
endmodule

module sas_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // cpu-side register values and write strobes
    input wire logic [7:0] peripheralEnableReg,
    input wire logic [7:0] converterModeReg,
    input wire logic modeWrite,
    input wire logic [7:0] triggerModeReg,
    input wire logic trigModeWrite,
    input wire logic [7:0] channelSelectReg,
    input wire logic chanSelWrite,
    // timer trigger pulses
    input wire logic timerTrig0,
    input wire logic timerTrig1,
    // analog front end
    input wire logic compHigh,
    output logic sampleHold,
    output logic [9:0] tapCode,
    output logic [3:0] analogChannel,
    output logic comparatorOn,
    // result registers and status
    output logic [15:0] resultWordReg,
    output logic [7:0] resultHighByteReg,
    output logic conversionEndIrq,
    output logic busy,
    output logic waitingTrigger,
    // result stream
    output sas_pkg::sas_sample_t streamData,
    output logic streamValid,
    input wire logic streamReady
);
    import sas_pkg::*;

    sas_state_t state;
    sas_state_t next_state;
    sas_mode_t mode;
    logic clkOn;
    logic timerMode;
    logic anyTrig;
    logic anyWrite;
    logic busyState;
    logic abortNow;
    logic [9:0] successive_approx_reg;
    logic [3:0] bitIdx;
    logic [7:0] cnt;
    logic [7:0] sampleLen;
    logic [7:0] bitLen;
    logic bitTick;
    logic enterSample;
    logic [1:0] scanSlot;
    logic [3:0] next_channel;
    logic pushValid;
    logic pushReady;
    logic storeFire;
    sas_sample_t pushData;

    // gated converter clock: the sequencer holds while it is off; the result stream still drains
    assign clkOn = peripheralEnableReg[`SAS_PEN_CLK_BIT]; // R1
    // one driver for the whole decoded word
    assign mode = '{start: converterModeReg[`SAS_MODE_START_BIT], // R3
        scan: converterModeReg[`SAS_MODE_SCAN_BIT], // R2
        convTime: converterModeReg[`SAS_MODE_TIME_HI:`SAS_MODE_TIME_LO], // R2
        compEn: converterModeReg[`SAS_MODE_COMP_BIT]};
    assign timerMode = triggerModeReg[`SAS_TRIG_TIMER_BIT]; // R18
    assign anyTrig = timerTrig0 || timerTrig1; // R19
    assign anyWrite = modeWrite || trigModeWrite || chanSelWrite;

    // time field sets both windows; slow settings give the comparator longer
    assign sampleLen = 8'((mode.convTime + 6'h01) * `SAS_SAMPLE_UNIT); // R24
    assign bitLen = 8'((mode.convTime + 6'h01) * `SAS_BIT_UNIT); // R24
    assign bitTick = (cnt == 8'h00);

    assign busyState = (state == ST_SAMPLE) || (state == ST_CONVERT) || (state == ST_STORE);
    // writes abort in both trigger modes, triggers only in timer mode
    assign abortNow = clkOn && mode.start && busyState
        && (anyWrite || (timerMode && anyTrig)); // R16 R20 R22

    assign pushValid = clkOn && mode.start && !abortNow && (state == ST_STORE);
    assign storeFire = pushValid && pushReady;
    assign pushData = '{channel: analogChannel, code: successive_approx_reg};

    always_comb begin
        next_state = state;
        if (!clkOn) begin
            next_state = state;
        end else if (!mode.start) begin
            next_state = ST_IDLE; // R12
        end else if (abortNow) begin
            next_state = ST_SAMPLE; // R16 R20 R22
        end else begin
            case (state)
                ST_IDLE: begin
                    next_state = timerMode ? ST_WAIT : ST_SAMPLE; // R4
                end
                ST_WAIT: begin
                    if (anyTrig || !timerMode) begin
                        next_state = ST_SAMPLE; // R19
                    end
                end
                ST_SAMPLE: begin
                    if (bitTick) begin
                        next_state = ST_CONVERT; // R5
                    end
                end
                ST_CONVERT: begin
                    if (bitTick && (bitIdx == 4'h0)) begin
                        next_state = ST_STORE; // R9
                    end
                end
                ST_STORE: begin
                    // back-pressure: stall here until the stream buffer has room
                    if (pushReady) begin
                        if ((mode.scan && scanSlot != `SAS_SCAN_LAST) || !timerMode) begin
                            next_state = ST_SAMPLE; // R12 R23
                        end else begin
                            next_state = ST_WAIT; // R19
                        end
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    assign enterSample = (next_state == ST_SAMPLE) && ((state != ST_SAMPLE) || abortNow);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // sample and bit window counter
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt <= 8'h00;
        end else if (clkOn) begin
            if (enterSample) begin
                cnt <= sampleLen - 8'h01; // R24
            end else if (next_state == ST_CONVERT && (state != ST_CONVERT || bitTick)) begin
                cnt <= bitLen - 8'h01; // R24
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end
        end
    end

    // successive approximation
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            successive_approx_reg <= 10'h000;
            bitIdx <= 4'h0;
        end else if (clkOn) begin
            if (state == ST_SAMPLE && next_state == ST_CONVERT) begin
                successive_approx_reg <= `SAS_SAR_MSB_SET; // R6
                bitIdx <= `SAS_SAR_TOP; // R6
            end else if (state == ST_CONVERT && bitTick && !abortNow && mode.start) begin
                // comparator is taken only at the end of the bit window
                if (!compHigh) begin
                    successive_approx_reg[bitIdx] <= 1'b0; // R7 R9 R25
                end
                if (bitIdx != 4'h0) begin
                    successive_approx_reg[bitIdx - 4'h1] <= 1'b1; // R8
                    bitIdx <= bitIdx - 4'h1; // R9
                end
            end
        end
    end

    // scan slot: writes and stops send the scan back to slot 0
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            scanSlot <= 2'h0;
        end else if (clkOn) begin
            if (!mode.start || abortNow || anyWrite) begin
                scanSlot <= 2'h0; // R20 R22
            end else if (storeFire) begin
                scanSlot <= mode.scan ? scanSlot + 2'h1 : 2'h0; // R21 R23
            end
        end
    end

    // result registers and end-of-conversion pulse
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            resultWordReg <= `SAS_WORD_RESET; // R17
            resultHighByteReg <= `SAS_HIGH_RESET; // R17
            conversionEndIrq <= 1'b0;
        end else begin
            if (storeFire) begin
                resultWordReg <= {successive_approx_reg, `SAS_RESULT_PAD}; // R10 R14 R15
                resultHighByteReg <= successive_approx_reg[9:2]; // R14
            end
            conversionEndIrq <= storeFire; // R11 R21 R23
        end
    end

    assign next_channel = mode.scan
        ? 4'(channelSelectReg[`SAS_CHAN_HI:`SAS_CHAN_LO] + {2'h0, scanSlot})
        : channelSelectReg[`SAS_CHAN_HI:`SAS_CHAN_LO];

    // analog-side controls and busy/wait status, all registered
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sampleHold <= 1'b0;
            tapCode <= 10'h000;
            analogChannel <= 4'h0;
            comparatorOn <= 1'b0;
            busy <= 1'b0;
            waitingTrigger <= 1'b0;
        end else begin
            sampleHold <= (next_state == ST_CONVERT) || (next_state == ST_STORE); // R5
            tapCode <= successive_approx_reg; // R6 R8
            analogChannel <= next_channel;
            comparatorOn <= clkOn && mode.compEn;
            busy <= (next_state == ST_SAMPLE) || (next_state == ST_CONVERT)
                || (next_state == ST_STORE);
            waitingTrigger <= (next_state == ST_WAIT); // R4
        end
    end

    sas_fifo #(
        .WIDTH($bits(sas_sample_t)),
        .DEPTH(`SAS_FIFO_DEPTH)
    ) u_fifo (
        .clk(ref_clk),
        .rst(sys_rst),
        .inData(pushData),
        .inValid(pushValid),
        .inReady(pushReady),
        .outData(streamData),
        .outValid(streamValid),
        .outReady(streamReady)
    );

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_trig_arrives;
        state == ST_WAIT && anyTrig && mode.start && clkOn;
    endsequence

    sequence s_bit_decide;
        state == ST_CONVERT && bitTick && clkOn && mode.start && !abortNow;
    endsequence

    property p_reset_clear;
        disable iff (1'b0)
        sys_rst |=> resultWordReg == 16'h0000 && resultHighByteReg == 8'h00;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("result not cleared"); // R17

    property p_scale;
        resultWordReg[5:0] == 6'h00 && resultWordReg[15:8] == resultHighByteReg;
    endproperty
    a_scale: assert property (p_scale) else $error("result word layout wrong"); // R15

    property p_irq_result;
        conversionEndIrq |-> resultWordReg == {$past(successive_approx_reg), 6'h00};
    endproperty
    a_irq_result: assert property (p_irq_result) else $error("irq without result"); // R11

    property p_msb_first;
        $rose(state == ST_CONVERT) |-> successive_approx_reg == 10'h200 && bitIdx == 4'h9;
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("msb not set first"); // R6

    property p_hold;
        (state == ST_CONVERT || state == ST_STORE) |-> sampleHold;
    endproperty
    a_hold: assert property (p_hold) else $error("not holding in convert"); // R5

    property p_clear_bit;
        s_bit_decide ##0 !compHigh |=> successive_approx_reg[$past(bitIdx)] == 1'b0;
    endproperty
    a_clear_bit: assert property (p_clear_bit) else $error("trial bit kept"); // R9

    property p_next_bit;
        s_bit_decide ##0 bitIdx != 4'h0 |=> successive_approx_reg[$past(bitIdx) - 4'h1] && tapCode == $past(successive_approx_reg);
    endproperty
    a_next_bit: assert property (p_next_bit) else $error("next bit not set"); // R8

    property p_wait_trig;
        state == ST_WAIT && !anyTrig && timerMode && mode.start && clkOn
            |=> state == ST_WAIT;
    endproperty
    a_wait_trig: assert property (p_wait_trig) else $error("left wait without trigger"); // R4

    property p_trig_start;
        s_trig_arrives |=> state == ST_SAMPLE ##1 busy;
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("trigger did not start"); // R19

    property p_stop;
        clkOn && !mode.start |=> state == ST_IDLE && !busy;
    endproperty
    a_stop: assert property (p_stop) else $error("did not stop"); // R12

    property p_abort;
        abortNow |=> state == ST_SAMPLE && scanSlot == 2'h0;
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not restart"); // R22

    property p_scan_step;
        storeFire && mode.scan && !anyWrite |=> scanSlot == $past(scanSlot) + 2'h1;
    endproperty
    a_scan_step: assert property (p_scan_step) else $error("scan slot not advanced"); // R23

    property p_sample_len;
        state == ST_SAMPLE && cnt != 8'h00 && clkOn && mode.start && !abortNow
            |=> state == ST_SAMPLE && !sampleHold;
    endproperty
    a_sample_len: assert property (p_sample_len) else $error("sample cut short"); // R24
endmodule

// ### sas_map.svh
// sas_map.svh: bit positions, reset values and timing counts of the converter sequencer
// assumes: included by bare name from the sequencer design file only
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH

// peripheral enable register
`define SAS_PEN_CLK_BIT 5
// converter mode register fields
`define SAS_MODE_START_BIT 7
`define SAS_MODE_SCAN_BIT 6
`define SAS_MODE_TIME_HI 5
`define SAS_MODE_TIME_LO 1
`define SAS_MODE_COMP_BIT 0
// trigger mode register: timer trigger when set
`define SAS_TRIG_TIMER_BIT 7
// channel select field
`define SAS_CHAN_HI 3
`define SAS_CHAN_LO 0
// approximation register
`define SAS_SAR_TOP 4'h9
`define SAS_SAR_MSB_SET 10'h200
`define SAS_RESULT_PAD 6'h00
// result reset values
`define SAS_WORD_RESET 16'h0000
`define SAS_HIGH_RESET 8'h00
// converter clocks per conversion-time step
`define SAS_SAMPLE_UNIT 8'h02
`define SAS_BIT_UNIT 8'h01
// scan slots run 0..3
`define SAS_SCAN_LAST 2'h3
// result stream buffer
`define SAS_FIFO_DEPTH 8

`endif

// ### sas_pkg.sv
// sas_pkg.sv: types shared by the converter sequencer and its result stream
// assumes: nothing beyond a SystemVerilog compiler
package sas_pkg;

    // gray along idle, wait, sample, convert, store
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_WAIT    = 3'h1,
        ST_SAMPLE  = 3'h3,
        ST_CONVERT = 3'h2,
        ST_STORE   = 3'h6
    } sas_state_t;

    // decoded converter mode register
    typedef struct packed {
        logic start;
        logic scan;
        logic [4:0] convTime;
        logic compEn;
    } sas_mode_t;

    // one finished conversion on the result stream
    typedef struct packed {
        logic [3:0] channel;
        logic [9:0] code;
    } sas_sample_t;

endpackage

// ### sas_afe_model.sv
// sas_afe_model.sv: behavioural sample-hold and comparator beside the sequencer
// assumes: one fixed voltage code per channel, ideal comparator, one clock
module sas_afe_model (
    // clock
    input wire logic ref_clk,
    // sequencer side
    input wire logic sampleHold,
    input wire logic [9:0] tapCode,
    input wire logic [3:0] analogChannel,
    // decision back to the sequencer
    output logic compHigh
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] held = 10'h000;
    // distinct code per channel so a result names its channel
    function automatic logic [9:0] volt(input logic [3:0] c);
        return {c, 6'h2b};
    endfunction
    // track while sampling, freeze on hold
    always_ff @(posedge ref_clk) begin
        if (sampleHold == 1'b0) begin
            held <= volt(analogChannel);
        end
    end
    // level follows the tap, settled within each bit window
    assign compHigh = (held >= tapCode);
endmodule

// ### tb_sas_top.sv
// tb_sas_top.sv: self-checking bench for the converter sequencer
// assumes: the front-end model answers the comparator; inputs change at falling edges
module tb_sas_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sas_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] pen = 8'h00;
    logic [7:0] mode = 8'h00;
    logic modeWrite = 1'b0;
    logic [7:0] trig = 8'h00;
    logic trigModeWrite = 1'b0;
    logic [7:0] chan = 8'h03;
    logic chanSelWrite = 1'b0;
    logic timerTrig0 = 1'b0;
    logic timerTrig1 = 1'b0;
    logic compHigh;
    logic sampleHold;
    logic [9:0] tapCode;
    logic [3:0] analogChannel;
    logic comparatorOn;
    logic [15:0] resultWordReg;
    logic [7:0] resultHighByteReg;
    logic conversionEndIrq;
    logic busy;
    logic waitingTrigger;
    sas_sample_t streamData;
    logic streamValid;
    logic streamReady = 1'b1;
    int err_count = 0;
    int checks_done = 0;
    int n;
    // time field 2: sample 6, bit 3, period 37
    localparam int PERIOD = 37;

    sas_top DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .peripheralEnableReg(pen),
        .converterModeReg(mode), .modeWrite(modeWrite), .triggerModeReg(trig),
        .trigModeWrite(trigModeWrite), .channelSelectReg(chan), .chanSelWrite(chanSelWrite),
        .timerTrig0(timerTrig0), .timerTrig1(timerTrig1), .compHigh(compHigh),
        .sampleHold(sampleHold), .tapCode(tapCode), .analogChannel(analogChannel),
        .comparatorOn(comparatorOn), .resultWordReg(resultWordReg),
        .resultHighByteReg(resultHighByteReg), .conversionEndIrq(conversionEndIrq),
        .busy(busy), .waitingTrigger(waitingTrigger), .streamData(streamData),
        .streamValid(streamValid), .streamReady(streamReady));

    sas_afe_model afe (.ref_clk(ref_clk), .sampleHold(sampleHold), .tapCode(tapCode),
        .analogChannel(analogChannel), .compHigh(compHigh));

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    function automatic logic [9:0] volt(input logic [3:0] c);
        return {c, 6'h2b};
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic idle(input int k);
        repeat (k) @(negedge ref_clk);
    endtask

    // count falling edges until the end pulse, limit+1 when none
    task automatic wait_irq(input int limit, output int cnt);
        cnt = 0;
        do begin
            @(negedge ref_clk);
            cnt++;
        end while (conversionEndIrq !== 1'b1 && cnt <= limit);
    endtask

    task automatic wr_mode(input logic [7:0] v);
        @(negedge ref_clk);
        mode = v;
        modeWrite = 1'b1;
        @(negedge ref_clk);
        modeWrite = 1'b0;
    endtask

    task automatic pulse_trig(input bit which);
        @(negedge ref_clk);
        if (which) timerTrig1 = 1'b1;
        else timerTrig0 = 1'b1;
        @(negedge ref_clk);
        timerTrig0 = 1'b0;
        timerTrig1 = 1'b0;
    endtask

    task automatic check_result(input logic [3:0] c);
        logic [9:0] v;
        v = volt(c);
        check("word", resultWordReg, {v, 6'h00});
        check("high", {8'h00, resultHighByteReg}, {8'h00, v[9:2]});
        check("tap", {6'h00, tapCode}, {6'h00, v});
    endtask

    task automatic t_freeze();
        // comparator gets a full microsecond before any start
        pen = 8'h20;
        wr_mode(8'h01);
        idle(125);
        check("comp early", {15'h0, comparatorOn}, 16'h0001);
        pen = 8'h00;
        wr_mode(8'h85);
        idle(40);
        check("busy off", {15'h0, busy}, 16'h0000);
        pen = 8'h20;
    endtask

    task automatic t_software();
        wait_irq(80, n);
        check_result(4'h3);
        check("comp on", {15'h0, comparatorOn}, 16'h0001);
        wait_irq(80, n);
        check("period", n[15:0], PERIOD[15:0]);
        check("hold", {15'h0, sampleHold}, 16'h0000);
        wr_mode(8'h05);
        wait_irq(100, n);
        check("stopped", n[15:0], 16'd101);
    endtask

    task automatic t_chan_abort();
        wr_mode(8'h85);
        idle(15);
        chan = 8'h05;
        chanSelWrite = 1'b1;
        @(negedge ref_clk);
        chanSelWrite = 1'b0;
        wait_irq(80, n);
        check("restart", {15'h0, n >= PERIOD - 1}, 16'h0001);
        check_result(4'h5);
        check("channel", {12'h000, analogChannel}, 16'h0005);
    endtask

    task automatic t_scan();
        chan = 8'h02;
        wr_mode(8'hc5);
        for (int s = 0; s < 4; s++) begin
            wait_irq(80, n);
            check_result(4'h2 + s[3:0]);
        end
        wr_mode(8'h05);
        idle(60);
    endtask

    task automatic t_timer();
        @(negedge ref_clk);
        trig = 8'h80;
        trigModeWrite = 1'b1;
        @(negedge ref_clk);
        trigModeWrite = 1'b0;
        wr_mode(8'h85);
        idle(50);
        check("waiting", {14'h0, waitingTrigger, busy}, 16'h0002);
        pulse_trig(1'b1);
        wait_irq(80, n);
        check_result(4'h2);
        idle(10);
        check("rewait", {15'h0, waitingTrigger}, 16'h0001);
        pulse_trig(1'b0);
        idle(15);
        pulse_trig(1'b0);
        wait_irq(80, n);
        check("trig abort", {15'h0, n >= PERIOD - 1}, 16'h0001);
        wr_mode(8'h05);
        @(negedge ref_clk);
        trig = 8'h00;
        trigModeWrite = 1'b1;
        @(negedge ref_clk);
        trigModeWrite = 1'b0;
        idle(60);
    endtask

    task automatic t_fifo();
        int hits;
        hits = 0;
        streamReady = 1'b0;
        wr_mode(8'h85);
        do begin
            wait_irq(100, n);
            if (n <= 100) hits++;
        end while (n <= 100 && hits < 20);
        check("stored", hits[15:0], 16'd9);
        check("first", {2'b00, streamData}, {2'b00, 4'h2, volt(4'h2)});
        wr_mode(8'h05);
        streamReady = 1'b1;
        n = 0;
        while (streamValid === 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        check("drained", {15'h0, streamValid}, 16'h0000);
    endtask

    initial begin
        #100us;
        err_count++;
        end_sim();
    end

    initial begin
        idle(10);
        sys_rst = 1'b0;
        check("word rst", resultWordReg, 16'h0000);
        check("high rst", {8'h00, resultHighByteReg}, 16'h0000);
        t_freeze();
        t_software();
        t_chan_abort();
        t_scan();
        t_timer();
        t_fifo();
        end_sim();
    end
endmodule
